// file: ext_bus_defs.svh
`ifndef EXT_BUS_DEFS_SVH
`define EXT_BUS_DEFS_SVH

// ----------------------------------------
// machine cycle timing, in oscillator ticks
// ----------------------------------------
`define CYC_STD_LEN 4'hc
`define CYC_DBL_LEN 4'h6
// strobe pulse positions, standard mode phase
`define LATCH_A_PH 4'h0
`define LATCH_B_PH 4'h6
`define FETCH_A_PH 4'h2
`define FETCH_B_PH 4'h8
`define STROBE_W 4'h2
// ----------------------------------------
// reset pin timing
// ----------------------------------------
`define RST_MC_CYCLES 2
`define WDOG_RST_TICKS 8'h60
// latch strobe disable bit position in the aux control value
`define AUX_LATCH_OFF_BIT 0

`endif

// file: ext_bus_pkg.sv
package ext_bus_pkg;
    // kind of the current machine cycle on the bus
    typedef enum logic [1:0] {
        CYC_INT_FETCH = 2'b00,
        CYC_EXT_FETCH = 2'b01,
        CYC_DATA_RD = 2'b10,
        CYC_DATA_WR = 2'b11
    } cyc_kind_t;
endpackage

// file: reset_pin_ctl.sv
`timescale 1ns/1ns
`include "ext_bus_defs.svh"

// ----------------------------------------
// reset pin: input filter and watchdog drive
// ----------------------------------------
module reset_pin_ctl (
    input wire logic sys_clk_i,
    input wire logic nrst_core_i,
    input wire logic mc_tick_i,
    input wire logic rst_pin_i,
    input wire logic wdog_rst_i,
    output logic rst_req_o,
    output logic rst_pin_o,
    output logic rst_pin_oe_o
);
    typedef struct packed {
        logic [1:0] high_mc;   // machine cycles seen high
        logic drive;           // pin driven, kept as a flop for the output
        logic [7:0] drive_cnt; // ticks left driving pin
        logic req;
    } rpin_t;

    rpin_t st;
    rpin_t next_st;

    // count machine cycles with the pin high
    always_comb begin
        next_st = st;
        next_st.req = 1'b0;
        if (st.drive_cnt != 8'h00) begin
            // own drive reads back high, do not count it twice
            next_st.drive_cnt = st.drive_cnt - 8'h01;
        end else if (wdog_rst_i) begin
            next_st.drive_cnt = `WDOG_RST_TICKS;
        end else if (!rst_pin_i) begin
            next_st.high_mc = 2'h0;
        end else if (mc_tick_i) begin
            if (st.high_mc == 2'(`RST_MC_CYCLES - 1)) begin
                next_st.req = 1'b1;
                next_st.high_mc = 2'h0;
            end else begin
                next_st.high_mc = st.high_mc + 2'h1;
            end
        end
        // registered drive flag so the pin outputs leave a flop directly
        next_st.drive = next_st.drive_cnt != 8'h00;
        if (st.drive_cnt != 8'h00 || wdog_rst_i) begin
            next_st.req = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_core_i) begin
        if (!nrst_core_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rst_req_o = st.req;
    assign rst_pin_o = st.drive;
    assign rst_pin_oe_o = st.drive;
endmodule

// file: ext_bus_strobes.sv
`timescale 1ns/1ns
`include "ext_bus_defs.svh"

module ext_bus_strobes (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic double_speed_mode_i,
    input wire logic [7:0] aux_control_reg_i,
    input wire logic external_code_select_i,
    input wire logic security_lvl1_i,
    input wire logic code_in_internal_i,
    input wire ext_bus_pkg::cyc_kind_t data_req_i,
    input wire logic rst_pin_i,
    input wire logic wdog_rst_i,
    output logic addr_latch_o,
    output logic program_fetch_strobe_n_o,
    output logic data_wr_n_o,
    output logic data_rd_n_o,
    output logic mc_tick_o,
    output logic ext_fetch_o,
    output logic rst_req_o,
    output logic rst_pin_o,
    output logic rst_pin_oe_o
);
    import ext_bus_pkg::*;

    // ----------------------------------------
    // reset release
    // ----------------------------------------
    logic [1:0] rst_sync; // two-stage release
    logic rst_n;          // synchronised reset

    // release reset cleanly to avoid a split first cycle
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [3:0] phase;     // osc tick in machine cycle
        cyc_kind_t kind;       // kind of current cycle
        logic sel_held;        // captured select level
        logic sel_caught;      // capture done after reset
        logic ale;
        logic fetch_n;
        logic wr_n;
        logic rd_n;
        logic tick;
        logic ext;
    } bus_t;

    bus_t st;      // registered state
    bus_t next_st; // next state

    logic [3:0] last_ph;  // final phase of a cycle
    logic [3:0] ph_std;   // phase in standard units
    logic use_sel;        // select value in force
    logic go_ext;         // code fetched externally
    logic latch_off;      // aux disable bit

    // ----------------------------------------
    // strobe generation
    // ----------------------------------------
    // double speed halves the cycle, so phases scale by two
    always_comb begin
        next_st = st;
        last_ph = double_speed_mode_i ? (`CYC_DBL_LEN - 4'h1) : (`CYC_STD_LEN - 4'h1);
        ph_std = double_speed_mode_i ? {st.phase[2:0], 1'b0} : st.phase;
        latch_off = aux_control_reg_i[`AUX_LATCH_OFF_BIT];
        // level 1 uses the captured level, else the live pin
        use_sel = security_lvl1_i ? st.sel_held : external_code_select_i;
        // select low means all code comes from outside
        go_ext = !use_sel || !code_in_internal_i;
        // catch the select pin once after reset release
        if (!st.sel_caught) begin
            next_st.sel_held = external_code_select_i;
            next_st.sel_caught = 1'b1;
        end
        // advance machine cycle, sample the next cycle kind
        next_st.tick = 1'b0;
        if (st.phase >= last_ph) begin
            next_st.phase = 4'h0;
            next_st.tick = 1'b1;
            // decision only moves with the cycle kind, so it never disagrees with the strobes
            next_st.ext = go_ext;
            if (data_req_i == CYC_DATA_RD || data_req_i == CYC_DATA_WR) begin
                next_st.kind = data_req_i;
            end else begin
                next_st.kind = go_ext ? CYC_EXT_FETCH : CYC_INT_FETCH;
            end
        end else begin
            next_st.phase = st.phase + 4'h1;
        end
        // latch strobe: two pulses per fetch cycle unless silenced, one per data cycle
        next_st.ale = 1'b0;
        if (ph_std < `STROBE_W) begin
            // first pulse latches low address of any access but a silenced internal fetch
            unique case (st.kind)
                CYC_INT_FETCH: next_st.ale = !latch_off;
                CYC_EXT_FETCH, CYC_DATA_RD, CYC_DATA_WR: next_st.ale = 1'b1;
            endcase
        end else if (ph_std >= `LATCH_B_PH && ph_std < `LATCH_B_PH + `STROBE_W) begin
            unique case (st.kind)
                CYC_INT_FETCH: next_st.ale = !latch_off;
                CYC_EXT_FETCH: next_st.ale = 1'b1;
                CYC_DATA_RD, CYC_DATA_WR: next_st.ale = 1'b0;
            endcase
        end
        // fetch strobe: low twice per external fetch cycle
        next_st.fetch_n = 1'b1;
        if ((ph_std >= `FETCH_A_PH && ph_std < `FETCH_A_PH + `STROBE_W) ||
            (ph_std >= `FETCH_B_PH && ph_std < `FETCH_B_PH + `STROBE_W)) begin
            // data cycles skip both, internal fetch never strobes
            next_st.fetch_n = !(st.kind == CYC_EXT_FETCH);
        end
        // data strobes span the middle of a data cycle
        next_st.wr_n = 1'b1;
        next_st.rd_n = 1'b1;
        if (ph_std >= `FETCH_A_PH && ph_std < `FETCH_B_PH + `STROBE_W) begin
            next_st.wr_n = !(st.kind == CYC_DATA_WR);
            next_st.rd_n = !(st.kind == CYC_DATA_RD);
        end
    end

    // register the whole state
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            st <= '{phase: 4'h0, kind: CYC_INT_FETCH, sel_held: 1'b1,
                    sel_caught: 1'b0, ale: 1'b0, fetch_n: 1'b1, wr_n: 1'b1,
                    rd_n: 1'b1, tick: 1'b0, ext: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign addr_latch_o = st.ale;
    assign program_fetch_strobe_n_o = st.fetch_n;
    assign data_wr_n_o = st.wr_n;
    assign data_rd_n_o = st.rd_n;
    assign mc_tick_o = st.tick;
    assign ext_fetch_o = st.ext;

    // ----------------------------------------
    // reset pin handling
    // ----------------------------------------
    // reset pin logic shares the released core reset, no split first cycle
    reset_pin_ctl u_rpin (
        .sys_clk_i(sys_clk_i),
        .nrst_core_i(rst_n),
        .mc_tick_i(st.tick),
        .rst_pin_i(rst_pin_i),
        .wdog_rst_i(wdog_rst_i),
        .rst_req_o(rst_req_o),
        .rst_pin_o(rst_pin_o),
        .rst_pin_oe_o(rst_pin_oe_o)
    );
endmodule

// file: ext_bus_strobes_asserts.sv
`timescale 1ns/1ns
module ext_bus_strobes_chk (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic double_speed_mode_i,
    input wire logic [7:0] aux_control_reg_i,
    input wire logic wdog_rst_i,
    input wire logic addr_latch_o,
    input wire logic program_fetch_strobe_n_o,
    input wire logic data_wr_n_o,
    input wire logic data_rd_n_o,
    input wire logic ext_fetch_o,
    input wire logic rst_pin_o,
    input wire logic rst_pin_oe_o
);
    // one clock domain, so one default clock and disable
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    a_data_no_latch: assert property (!data_rd_n_o || !data_wr_n_o |-> !addr_latch_o)
        else $error("latch pulse inside data strobe");
    a_data_no_fetch: assert property (!data_rd_n_o || !data_wr_n_o |-> program_fetch_strobe_n_o)
        else $error("fetch strobe inside data strobe");
    a_data_excl: assert property (!(!data_rd_n_o && !data_wr_n_o))
        else $error("read and write strobes together");
    a_latch_rate: assert property ($rose(addr_latch_o) && !double_speed_mode_i |->
        ##6 ($rose(addr_latch_o) || !data_rd_n_o || !data_wr_n_o)) else $error("latch rate off");
    a_fetch_width: assert property ($fell(program_fetch_strobe_n_o) && !double_speed_mode_i |=>
        !program_fetch_strobe_n_o ##1 program_fetch_strobe_n_o) else $error("fetch width off");
    a_int_no_fetch: assert property (!ext_fetch_o && !$past(ext_fetch_o) |->
        program_fetch_strobe_n_o) else $error("fetch strobe on internal code");
    // a silenced latch may only pulse ahead of a data strobe
    a_latch_quiet: assert property (aux_control_reg_i[0] && !ext_fetch_o &&
        $rose(addr_latch_o) |-> ##[1:3] (!data_rd_n_o || !data_wr_n_o)) else $error("latch not quiet");
    a_wdog_drive: assert property ($rose(wdog_rst_i) |=> rst_pin_oe_o && rst_pin_o)
        else $error("watchdog not driving pin");
    c_read: cover property ($fell(data_rd_n_o));
    c_write: cover property ($fell(data_wr_n_o));
    c_wdog: cover property ($rose(rst_pin_oe_o));
endmodule

bind ext_bus_strobes ext_bus_strobes_chk u_ext_bus_strobes_chk (.*);

// file: mem_side_model.sv
`timescale 1ns/1ns
module mem_side_model (
    input wire logic sys_clk_i,
    input wire logic clr_i,
    input wire logic use_ext_i,
    input wire logic addr_latch_i,
    input wire logic fetch_n_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    output logic external_code_select_o,
    output logic [7:0] latch_cnt_o,
    output logic [7:0] fetch_cnt_o,
    output logic [7:0] rd_cnt_o,
    output logic [7:0] wr_cnt_o
);
    logic [3:0] prev; // strobe levels one tick back
    // select held low while code lives in outside memory
    assign external_code_select_o = !use_ext_i;
    // latch captures on each rise, memories answer each falling strobe
    always_ff @(posedge sys_clk_i) begin
        prev <= {addr_latch_i, fetch_n_i, rd_n_i, wr_n_i};
        latch_cnt_o <= clr_i ? 8'h00 : latch_cnt_o + 8'(addr_latch_i && !prev[3]);
        fetch_cnt_o <= clr_i ? 8'h00 : fetch_cnt_o + 8'(!fetch_n_i && prev[2]);
        rd_cnt_o <= clr_i ? 8'h00 : rd_cnt_o + 8'(!rd_n_i && prev[1]);
        wr_cnt_o <= clr_i ? 8'h00 : wr_cnt_o + 8'(!wr_n_i && prev[0]);
    end
endmodule

// file: test_ext_bus_strobes.sv
`timescale 1ns/1ns
`include "ext_bus_defs.svh"
module test_ext_bus_strobes;
    import ext_bus_pkg::*;
    logic sys_clk_i = 0, nrst_i = 0, dsm = 0, use_ext = 1, sec = 0, clr = 0, pin_drv = 0, wdog = 0;
    logic [7:0] aux = 8'h00;
    cyc_kind_t req = CYC_INT_FETCH;
    logic sel, latch, fetch_n, wr_n, rd_n, tick, extf, rreq, pin_o, pin_oe;
    logic [7:0] n_latch, n_fetch, n_rd, n_wr, n;
    int fails = 0, total_checks = 0, i;
    initial forever #50 sys_clk_i = !sys_clk_i;
    ext_bus_strobes u_ext_bus_strobes (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
        .double_speed_mode_i(dsm), .aux_control_reg_i(aux), .external_code_select_i(sel),
        .security_lvl1_i(sec), .code_in_internal_i(!use_ext), .data_req_i(req),
        .rst_pin_i(pin_oe ? pin_o : pin_drv), .wdog_rst_i(wdog), .addr_latch_o(latch),
        .program_fetch_strobe_n_o(fetch_n), .data_wr_n_o(wr_n), .data_rd_n_o(rd_n),
        .mc_tick_o(tick), .ext_fetch_o(extf), .rst_req_o(rreq), .rst_pin_o(pin_o),
        .rst_pin_oe_o(pin_oe));
    mem_side_model u_mem_side_model (.sys_clk_i(sys_clk_i), .clr_i(clr), .use_ext_i(use_ext),
        .addr_latch_i(latch), .fetch_n_i(fetch_n), .rd_n_i(rd_n), .wr_n_i(wr_n),
        .external_code_select_o(sel), .latch_cnt_o(n_latch), .fetch_cnt_o(n_fetch),
        .rd_cnt_o(n_rd), .wr_cnt_o(n_wr));
    task conclude;
        $display("fails %0d total_checks %0d", fails, total_checks);
        if (fails == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    // bounded wait for the next machine cycle start
    task wait_tick;
        for (i = 0; i < 40 && tick !== 1'b1; i++) @(negedge sys_clk_i);
        if (tick !== 1'b1) begin
            fails++;
            conclude();
        end
        @(negedge sys_clk_i);
    endtask
    // reset with new mode, then count strobes over four machine cycles
    task burst(input logic d, e, a0, s, input cyc_kind_t k, input logic [7:0] el, ef, er, ew);
        @(posedge sys_clk_i);
        nrst_i <= 0;
        {dsm, use_ext, sec, req} <= {d, e, s, k};
        aux <= {7'h00, a0};
        repeat (3) @(posedge sys_clk_i);
        nrst_i <= 1;
        wait_tick();
        wait_tick();
        @(posedge sys_clk_i);
        clr <= 1;
        @(posedge sys_clk_i);
        clr <= 0;
        repeat (d ? 24 : 48) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        check("latch pulses", n_latch, el);
        check("fetch strobes", n_fetch, ef);
        check("read strobes", n_rd, er);
        check("write strobes", n_wr, ew);
    endtask
    // pin held for a number of ticks, count reset requests seen
    task pin_test(input int hold, input logic [7:0] exp);
        n = 0;
        wait_tick();
        @(posedge sys_clk_i);
        pin_drv <= 1;
        for (i = 0; i < 40; i++) begin
            @(posedge sys_clk_i);
            if (i == hold) pin_drv <= 0;
            @(negedge sys_clk_i);
            n = n + {7'h00, rreq};
        end
        check("pin reset", n, exp);
    endtask
    initial begin
        burst(0, 1, 0, 0, CYC_INT_FETCH, 8'h08, 8'h08, 8'h00, 8'h00);
        burst(1, 1, 0, 0, CYC_INT_FETCH, 8'h08, 8'h08, 8'h00, 8'h00);
        burst(0, 1, 0, 0, CYC_DATA_RD, 8'h04, 8'h00, 8'h04, 8'h00);
        burst(1, 1, 1, 0, CYC_DATA_WR, 8'h04, 8'h00, 8'h00, 8'h04);
        burst(0, 0, 1, 0, CYC_INT_FETCH, 8'h00, 8'h00, 8'h00, 8'h00);
        burst(0, 0, 0, 0, CYC_EXT_FETCH, 8'h08, 8'h00, 8'h00, 8'h00);
        burst(0, 0, 1, 0, CYC_DATA_RD, 8'h04, 8'h00, 8'h04, 8'h00);
        burst(0, 1, 1, 0, CYC_INT_FETCH, 8'h08, 8'h08, 8'h00, 8'h00);
        burst(0, 1, 0, 1, CYC_INT_FETCH, 8'h08, 8'h08, 8'h00, 8'h00);
        @(posedge sys_clk_i);
        use_ext <= 0;
        wait_tick();
        wait_tick();
        check("captured select", extf, 1'b1);
        pin_test(10, 8'h00);
        pin_test(26, 8'h01);
        n = 0;
        @(posedge sys_clk_i);
        wdog <= 1;
        @(posedge sys_clk_i);
        wdog <= 0;
        for (i = 0; i < 120; i++) begin
            @(negedge sys_clk_i);
            n = n + {7'h00, pin_oe && pin_o};
        end
        check("watchdog drive", n, `WDOG_RST_TICKS);
        conclude();
    end
endmodule
